// File: pkg/tec_regs.svh
// Register offsets, field positions, reset values of the timer/event counter
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH
`define TEC_OFF_CONTROL      8'h00
`define TEC_OFF_VALUE        8'h04
`define TEC_OFF_CLKSEL       8'h08
`define TEC_OFF_IRQCTL       8'h0C
`define TEC_OFF_STATUS       8'h10
`define TEC_BIT_EDGE         3
`define TEC_BIT_RUN          4
`define TEC_CTRL_RESET       8'h08
`define TEC_CTRL_WMASK       8'hDF
`define TEC_CLKSEL_RESET     2'h0
`define TEC_PRELOAD_RESET    8'h00
`define TEC_FULL_COUNT       8'hFF
`define TEC_INSTR_DIV        2'h3
`endif

// File: pkg/tec_pkg.sv
// Types of the timer/event counter
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_MODE_NONE,
    TEC_MODE_EVENT,
    TEC_MODE_TIMER,
    TEC_MODE_CAPTURE
  } tec_mode_t;

  typedef struct packed {
    tec_mode_t  op_mode_select;
    logic       unused5;
    logic       count_run_enable;
    logic       active_edge_select;
    logic [2:0] prescale_rate_select;
  } tec_ctrl_t;

  typedef enum logic [1:0] {
    TEC_CAP_IDLE,
    TEC_CAP_MEASURE
  } tec_cap_t;
endpackage

// File: core/tec_timer_event_counter8.sv
// Timer/event counter with an AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tec_regs.svh"

// Function
// - Timer mode uses selectable internal clock source
// - Three-bit prescaler divides by 1 to 128
// - Pin events bypass the prescaler
// - Increment; past FFH overflow, interrupt, reload
// - Disabled: preload write also loads counter
// - Enabled: preload write waits for overflow
// - Bits 7:6 select the operating mode
// - Bit 4 enables counting
// - Event mode edge select: rising or falling
// - Capture mode edges start and stop counting
// - Timer counts on prescaled clock falling edge
// - Overflow interrupt gated by enable bit
// - Overflow during SLEEP raises wake-up
// - Event counting continues during sleep
// - Control bit 5 reads zero
// - Capture end clears enable bit itself
module tec_timer_event_counter8
  import tec_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        LOW_SPEED_INTERNAL_OSC_TICK,
  input  wire logic        EXTERNAL_COUNT_PIN,
  input  wire logic        SLEEP,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             OVERFLOW_IRQ,
  output logic             WAKEUP
);

  // AXI write path
  logic       aw_held_r;
  logic [7:0] aw_addr_r;
  logic       w_held_r;
  logic [31:0] w_data_r;
  logic       w_strb0_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       arready_r;
  logic       rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire aw_take = S_AXI_AWVALID && !aw_held_r && !bvalid_r;
  wire w_take  = S_AXI_WVALID && !w_held_r && !bvalid_r;
  wire wr_go   = aw_held_r && w_held_r && !bvalid_r;
  wire wr_ctrl = wr_go && w_strb0_r && (aw_addr_r == `TEC_OFF_CONTROL);
  wire wr_val  = wr_go && w_strb0_r && (aw_addr_r == `TEC_OFF_VALUE);
  wire wr_clk  = wr_go && w_strb0_r && (aw_addr_r == `TEC_OFF_CLKSEL);
  wire wr_irq  = wr_go && w_strb0_r && (aw_addr_r == `TEC_OFF_IRQCTL);
  wire wr_hit  = (aw_addr_r == `TEC_OFF_CONTROL) || (aw_addr_r == `TEC_OFF_VALUE) ||
                 (aw_addr_r == `TEC_OFF_CLKSEL) || (aw_addr_r == `TEC_OFF_IRQCTL) ||
                 (aw_addr_r == `TEC_OFF_STATUS);
  wire ar_take = S_AXI_ARVALID && !arready_r && !rvalid_r;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (w_take) begin
        w_held_r  <= 1'b1;
        w_data_r  <= S_AXI_WDATA;
        w_strb0_r <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? 2'h0 : 2'h2;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Registers
  tec_ctrl_t  ctrl_r;
  logic [7:0] preload_r;
  logic [7:0] count_r;
  logic [1:0] clksel_r;
  logic       irq_en_r;
  logic       ovf_flag_r;

  // Clock source selection and prescaler
  logic [1:0] instr_div_r;
  logic [6:0] presc_r;
  logic [2:0] low_speed_internal_osc_sync_r;
  logic [2:0] pin_sync_r;

  wire low_speed_internal_osc_rise = low_speed_internal_osc_sync_r[1] && !low_speed_internal_osc_sync_r[2];
  wire instr_tick = (instr_div_r == `TEC_INSTR_DIV);
  wire src_tick = (clksel_r == 2'h0) ? 1'b1 :
                  (clksel_r == 2'h1) ? instr_tick :
                  low_speed_internal_osc_rise;
  wire [7:0] presc_next = {1'b0, presc_r} + 8'h01;
  // Falling edge of divided clock: bit p-1 drops from 1 to 0
  wire presc_fall = (ctrl_r.prescale_rate_select == 3'h0) ? src_tick :
                    (src_tick && presc_r[ctrl_r.prescale_rate_select - 3'h1] &&
                     !presc_next[ctrl_r.prescale_rate_select - 3'h1]);

  wire pin_lvl  = pin_sync_r[1];
  wire pin_rise = pin_sync_r[1] && !pin_sync_r[2];
  wire pin_fall = !pin_sync_r[1] && pin_sync_r[2];

  // Capture state
  tec_cap_t cap_r;
  wire mode_event = (ctrl_r.op_mode_select == TEC_MODE_EVENT);
  wire mode_timer = (ctrl_r.op_mode_select == TEC_MODE_TIMER);
  wire mode_cap   = (ctrl_r.op_mode_select == TEC_MODE_CAPTURE);
  wire run        = ctrl_r.count_run_enable;
  wire ev_edge    = ctrl_r.active_edge_select ? pin_fall : pin_rise;
  wire cap_start  = ctrl_r.active_edge_select ? pin_rise : pin_fall;
  wire cap_stop   = ctrl_r.active_edge_select ? pin_fall : pin_rise;
  wire cap_end    = mode_cap && run && (cap_r == TEC_CAP_MEASURE) && cap_stop;

  // Event mode ignores SLEEP, so pin counting goes on while asleep
  wire inc = run && ((mode_event && ev_edge) ||
                     (mode_timer && presc_fall) ||
                     (mode_cap && (cap_r == TEC_CAP_MEASURE) && !cap_stop && presc_fall));
  wire overflow = inc && (count_r == `TEC_FULL_COUNT);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      instr_div_r <= 2'h0;
      presc_r     <= 7'h00;
      low_speed_internal_osc_sync_r <= 3'h0;
      pin_sync_r  <= 3'h0;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
      low_speed_internal_osc_sync_r <= {low_speed_internal_osc_sync_r[1:0], LOW_SPEED_INTERNAL_OSC_TICK};
      pin_sync_r  <= {pin_sync_r[1:0], EXTERNAL_COUNT_PIN};
      if (!run || !(mode_timer || mode_cap)) begin
        presc_r <= 7'h00;
      end else if (src_tick) begin
        presc_r <= presc_next[6:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cap_r <= TEC_CAP_IDLE;
    end else if (!mode_cap || !run || cap_end) begin
      cap_r <= TEC_CAP_IDLE;
    end else begin
      case (cap_r)
        TEC_CAP_IDLE:    cap_r <= cap_start ? TEC_CAP_MEASURE : TEC_CAP_IDLE;
        TEC_CAP_MEASURE: cap_r <= TEC_CAP_MEASURE;
        default:         cap_r <= TEC_CAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_r    <= tec_ctrl_t'(`TEC_CTRL_RESET);
      preload_r <= `TEC_PRELOAD_RESET;
      clksel_r  <= `TEC_CLKSEL_RESET;
      irq_en_r  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= tec_ctrl_t'(w_data_r[7:0] & `TEC_CTRL_WMASK);
      end else if (cap_end) begin
        ctrl_r.count_run_enable <= 1'b0;
      end
      if (wr_val) begin
        preload_r <= w_data_r[7:0];
      end
      if (wr_clk) begin
        clksel_r <= w_data_r[1:0];
      end
      if (wr_irq) begin
        irq_en_r <= w_data_r[0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      count_r <= `TEC_PRELOAD_RESET;
    end else if (wr_val && !run) begin
      count_r <= w_data_r[7:0];
    end else if (overflow) begin
      count_r <= preload_r;
    end else if (inc) begin
      count_r <= count_r + 8'h01;
    end
  end

  // Sticky overflow flag, cleared by writing 1; a new overflow wins
  wire st_clr = wr_go && w_strb0_r && (aw_addr_r == `TEC_OFF_STATUS) && w_data_r[0];
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ovf_flag_r   <= 1'b0;
      OVERFLOW_IRQ <= 1'b0;
      WAKEUP       <= 1'b0;
    end else begin
      ovf_flag_r   <= overflow | (ovf_flag_r & ~st_clr);
      OVERFLOW_IRQ <= overflow && irq_en_r;
      WAKEUP       <= SLEEP && overflow;
    end
  end

  // AXI read path
  wire [7:0] ar_addr = {S_AXI_ARADDR[7:2], 2'b00};
  wire       rd_hit  = (ar_addr == `TEC_OFF_CONTROL) || (ar_addr == `TEC_OFF_VALUE) ||
                       (ar_addr == `TEC_OFF_CLKSEL) || (ar_addr == `TEC_OFF_IRQCTL) ||
                       (ar_addr == `TEC_OFF_STATUS);
  wire [7:0] rd_byte = (ar_addr == `TEC_OFF_CONTROL) ? (ctrl_r & `TEC_CTRL_WMASK) :
                       (ar_addr == `TEC_OFF_VALUE)   ? count_r :
                       (ar_addr == `TEC_OFF_CLKSEL)  ? {6'h00, clksel_r} :
                       (ar_addr == `TEC_OFF_IRQCTL)  ? {7'h00, irq_en_r} :
                       (ar_addr == `TEC_OFF_STATUS)  ? {6'h00, cap_r == TEC_CAP_MEASURE, ovf_flag_r} :
                       8'h00;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'h0;
    end else begin
      arready_r <= ar_take;
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, rd_byte};
        rresp_r  <= rd_hit ? 2'h0 : 2'h2;
      end else if (rvalid_r && S_AXI_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end else begin
      S_AXI_AWREADY <= aw_take && !S_AXI_AWREADY;
      S_AXI_WREADY  <= w_take && !S_AXI_WREADY;
    end
  end

  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

endmodule

// File: tb/tec_pin_src.sv
// Behavioural source of pulses on the external count pin
`timescale 1ns/1ps
module tec_pin_src (
  input wire logic clk,
  output logic     pin
);
  initial pin = 1'b0;
  task automatic go(input logic lvl);
    @(posedge clk);
    pin <= lvl;
  endtask
  // Each pulse leaves the idle level for w cycles, then rests w cycles
  task automatic pulses(input int n, input int w);
    logic idle;
    idle = pin;
    repeat (n) begin
      @(posedge clk);
      pin <= !idle;
      repeat (w) @(posedge clk);
      pin <= idle;
      repeat (w) @(posedge clk);
    end
  endtask
endmodule

// File: tb/tec_assertions.sv
// Port checks of the timer/event counter
`timescale 1ns/1ps
module tec_assertions (
  input wire logic        REF_CLK,
  input wire logic        RESET,
  input wire logic        SLEEP,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        WAKEUP
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence s_wr_taken;
    S_AXI_AWREADY && S_AXI_WREADY;
  endsequence
  sequence s_bad_wr;
    s_wr_taken ##0 (S_AXI_AWADDR[7:2] > 6'h04);
  endsequence
  a_wr_answer: assert property (s_wr_taken |=> S_AXI_BVALID) else $error("no bvalid");
  a_bad_wr: assert property (s_bad_wr |=> S_AXI_BRESP == 2'h2) else $error("bresp");
  a_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid");
  a_ar_answer: assert property (S_AXI_ARREADY |-> S_AXI_RVALID) else $error("rvalid");
  a_bit5_zero: assert property (S_AXI_ARREADY && S_AXI_ARADDR == 8'h00 |-> !S_AXI_RDATA[5])
    else $error("bit5");
  a_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000) else $error("upper");
  a_bad_rd: assert property (S_AXI_ARREADY && S_AXI_ARADDR[7:2] > 6'h04 |-> S_AXI_RRESP == 2'h2) else $error("rresp");
  a_wake_sleep: assert property (WAKEUP |-> $past(SLEEP)) else $error("wakeup");
endmodule
bind tec_timer_event_counter8 tec_assertions tec_assertions_inst (.REF_CLK, .RESET, .SLEEP, .S_AXI_AWADDR,
  .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .WAKEUP);

// File: tb/testbench.sv
// Self-checking bench of the timer/event counter
`timescale 1ns/1ps
module testbench;
  logic        REF_CLK, RESET, SLEEP, EXTERNAL_COUNT_PIN, OVERFLOW_IRQ, WAKEUP;
  logic        LOW_SPEED_INTERNAL_OSC_TICK = 1'b0;
  logic        S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdat, t0;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, resp;
  int          err_total, samples_checked, cyc, irqs, wakes, per, last;
  int          srcs[5]  = '{0, 0, 0, 1, 2};
  int          codes[5] = '{0, 3, 7, 0, 0};
  int          pers[5]  = '{16, 128, 2048, 64, 256};
  tec_timer_event_counter8 tec_timer_event_counter8_inst (.REF_CLK, .RESET, .LOW_SPEED_INTERNAL_OSC_TICK, .EXTERNAL_COUNT_PIN,
    .SLEEP, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .OVERFLOW_IRQ, .WAKEUP);
  tec_pin_src tec_pin_src_inst (.clk(REF_CLK), .pin(EXTERNAL_COUNT_PIN));
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc % 8 == 0) LOW_SPEED_INTERNAL_OSC_TICK <= ~LOW_SPEED_INTERNAL_OSC_TICK;
    if (WAKEUP === 1'b1) wakes++;
    if (OVERFLOW_IRQ === 1'b1) begin
      irqs++;
      per = cyc - last;
      last = cyc;
    end
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
    rdat = S_AXI_RDATA;
    resp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd(a);
    chk(rdat, exp, what);
  endtask
  task automatic ev(input int n);
    tec_pin_src_inst.pulses(n, 6);
  endtask
  initial begin
    {RESET, SLEEP, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 7'h40;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (4) @(posedge REF_CLK);
    RESET <= 1'b0;
    rchk(8'h00, 32'h0000_0008, "control");
    rchk(8'h04, 32'h0000_0000, "count");
    wr(8'h00, 32'h0000_00FF);
    rchk(8'h00, 32'h0000_00DF, "control bit5");
    wr(8'h00, 32'h0000_0000);
    rd(8'h14);
    chk(32'(resp), 32'h0000_0002, "rresp");
    wr(8'h04, 32'h0000_00F0);
    rchk(8'h04, 32'h0000_00F0, "preload off");
    wr(8'h00, 32'h0000_0057);
    ev(3);
    rchk(8'h04, 32'h0000_00F3, "rising");
    wr(8'h00, 32'h0000_0058);
    ev(3);
    rchk(8'h04, 32'h0000_00F6, "falling");
    wr(8'h0C, 32'h0000_0001);
    wr(8'h04, 32'h0000_00FD);
    rchk(8'h04, 32'h0000_00F6, "preload on");
    ev(10);
    rchk(8'h04, 32'h0000_00FD, "reload");
    chk(irqs, 1, "irq");
    rchk(8'h10, 32'h0000_0001, "status set");
    wr(8'h10, 32'h0000_0001);
    chk(32'(resp), 32'h0000_0000, "bresp");
    rchk(8'h10, 32'h0000_0000, "status clear");
    wr(8'h14, 32'h0000_0001);
    chk(32'(resp), 32'h0000_0002, "bresp bad");
    SLEEP <= 1'b1;
    ev(3);
    repeat (4) @(posedge REF_CLK);
    SLEEP <= 1'b0;
    chk(wakes, 1, "wake");
    chk(irqs, 2, "sleep irq");
    wr(8'h0C, 32'h0000_0000);
    ev(3);
    chk(irqs, 2, "masked irq");
    wr(8'h0C, 32'h0000_0001);
    foreach (codes[i]) begin
      wr(8'h00, 32'h0000_0000);
      wr(8'h08, srcs[i]);
      wr(8'h04, 32'h0000_00F0);
      wr(8'h00, 32'h0000_0090 | codes[i]);
      t0 = irqs + 2;
      while (irqs < t0) @(negedge REF_CLK);
      chk(per, pers[i], "period");
    end
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0000);
    tec_pin_src_inst.go(1'b1);
    wr(8'h00, 32'h0000_00D0);
    tec_pin_src_inst.pulses(1, 40);
    rchk(8'h00, 32'h0000_00C0, "capture end");
    rd(8'h04);
    t0 = rdat;
    chk(32'(t0 > 36 && t0 < 44), 32'h0000_0001, "width");
    ev(2);
    rchk(8'h04, t0, "after end");
    give_verdict();
  end
endmodule
